/* File: design/irq_entry_pkg.sv */
/*
 Package for the interrupt entry and return block: register offsets,
 field positions, reset values, vector and latency counts.
 Assumes a 32-bit APB slave and a core on the same 50 MHz clock.
*/
package irq_entry_pkg;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFF   = 8'h00;
   localparam logic [7:0] REQA_OFF   = 8'h04;
   localparam logic [7:0] REQB_OFF   = 8'h08;
   localparam logic [7:0] ENA_OFF    = 8'h0C;
   localparam logic [7:0] ENB_OFF    = 8'h10;
   localparam logic [7:0] STAT_OFF   = 8'h14;
   // Control register field positions
   localparam int GIE_BIT  = 7;
   localparam int PGE_BIT  = 6;
   localparam int CEN_LSB  = 3;
   localparam int CFL_LSB  = 0;
   localparam int CORE_SRC = 3;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] REQ_RST  = 8'h00;
   localparam logic [7:0] EN_RST   = 8'h00;
   // Vector and entry timing
   localparam logic [14:0] VECTOR_ADDR = 15'h0004;
   localparam int ENTRY_CYCLES = 3;
   // Core side request and answer carriers
   typedef struct packed {
      logic        flush;
      logic        push;
      logic        save_ctx;
      logic        load_pc;
      logic [14:0] pc;
   } core_cmd_type;
   typedef enum logic [1:0] {ST_RUN, ST_ENTRY, ST_SERVICE} irq_state_type;
endpackage : irq_entry_pkg

/* File: design/irq_entry_return.sv */
/*
 Interrupt recognition, entry and return sequencing for a small core.
 Assumes: core events arrive on the system clock; peripheral events may
 be asynchronous pins and are synchronised here; the core pulses
 RETI_I when it decodes the return instruction and handles stack and
 shadow copies itself when told to by the command outputs.
*/
`timescale 1ns/100ps
module irq_entry_return #(
   parameter int NUM_PERIPH = 16
) (
   input  wire logic                          CLK_SYS_I,
   input  wire logic                          RSTN_I,
   input  wire logic [2:0]                    CORE_EVT_I,
   input  wire logic [NUM_PERIPH-1:0]         PERIPH_EVT_I,
   input  wire logic                          RETI_I,
   input  wire logic [14:0]                   CORE_PC_I,
   output      irq_entry_pkg::core_cmd_type   CORE_CMD_O,
   output      logic                          CORE_RESTORE_O,
   output      logic                          IRQ_REQ_O,
   input  wire logic                          PSEL_I,
   input  wire logic                          PENABLE_I,
   input  wire logic                          PWRITE_I,
   input  wire logic [7:0]                    PADDR_I,
   input  wire logic [31:0]                   PWDATA_I,
   output      logic [31:0]                   PRDATA_O,
   output      logic                          PREADY_O,
   output      logic                          PSLVERR_O
);
   // Flag registers are two fixed bytes, so only sixteen sources fit
   if (NUM_PERIPH != 16) begin : g_bad_num
      $error("NUM_PERIPH must be 16");
   end

   logic [7:0]            ctrl_q;
   logic [15:0]           preq_q;
   logic [15:0]           pen_q;
   logic [15:0]           sync1_q;
   logic [15:0]           sync2_q;
   logic [15:0]           sync3_q;
   logic [15:0]           per_evt;
   logic                  wr_en;
   logic                  rd_hit;
   logic                  irq_any;
   logic                  take;
   logic [1:0]            lat_q;
   logic [3:0]            wait_q;
   logic                  gie_set;
   logic [2:0]            core_en;
   logic [2:0]            core_flag;
   irq_entry_pkg::irq_state_type state_q;

   // Two-flop sync per peripheral pin, third flop only for edge detect
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         sync1_q <= 16'h0000;
         sync2_q <= 16'h0000;
         sync3_q <= 16'h0000;
      end else begin
         sync1_q <= PERIPH_EVT_I;
         sync2_q <= sync1_q;
         sync3_q <= sync2_q;
      end
   end

   genvar g;
   generate
      for (g = 0; g < 16; g++) begin : g_edge
         assign per_evt[g] = sync2_q[g] & ~sync3_q[g];
      end
   endgenerate

   // APB decode; zero wait states, no error responses
   assign wr_en     = PSEL_I & PENABLE_I & PWRITE_I;
   assign rd_hit    = PSEL_I & ~PWRITE_I;
   assign PREADY_O  = 1'b1;
   assign PSLVERR_O = 1'b0;

   // Read mux registered in the setup phase so data stands at access
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         PRDATA_O <= 32'h0000_0000;
      end else if (rd_hit && !PENABLE_I) begin
         case (PADDR_I)
            irq_entry_pkg::CTRL_OFF: PRDATA_O <= {24'h000000, ctrl_q};
            irq_entry_pkg::REQA_OFF: PRDATA_O <= {24'h000000, preq_q[7:0]};
            irq_entry_pkg::REQB_OFF: PRDATA_O <= {24'h000000, preq_q[15:8]};
            irq_entry_pkg::ENA_OFF:  PRDATA_O <= {24'h000000, pen_q[7:0]};
            irq_entry_pkg::ENB_OFF:  PRDATA_O <= {24'h000000, pen_q[15:8]};
            irq_entry_pkg::STAT_OFF: PRDATA_O <= {30'h0, state_q};
            default:                 PRDATA_O <= 32'h0000_0000;
         endcase
      end
   end

   // Control: global enable, group enable, core enables, core flags
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         ctrl_q <= irq_entry_pkg::CTRL_RST;
      end else begin
         if (wr_en && PADDR_I == irq_entry_pkg::CTRL_OFF)
            ctrl_q <= PWDATA_I[7:0];
         if (take)
            ctrl_q[irq_entry_pkg::GIE_BIT] <= 1'b0;
         if (gie_set)
            ctrl_q[irq_entry_pkg::GIE_BIT] <= 1'b1;
         // Set beats a software clear in the same cycle
         ctrl_q[irq_entry_pkg::CFL_LSB +: irq_entry_pkg::CORE_SRC] <=
            ((wr_en && PADDR_I == irq_entry_pkg::CTRL_OFF)
             ? PWDATA_I[irq_entry_pkg::CFL_LSB +: irq_entry_pkg::CORE_SRC]
             : ctrl_q[irq_entry_pkg::CFL_LSB +: irq_entry_pkg::CORE_SRC])
            | CORE_EVT_I;
      end
   end

   // Peripheral request flags; hardware set wins over write
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         preq_q <= {irq_entry_pkg::REQ_RST, irq_entry_pkg::REQ_RST};
      end else begin
         preq_q <= ({(wr_en && PADDR_I == irq_entry_pkg::REQB_OFF)
                       ? PWDATA_I[7:0] : preq_q[15:8],
                     (wr_en && PADDR_I == irq_entry_pkg::REQA_OFF)
                       ? PWDATA_I[7:0] : preq_q[7:0]})
                   | per_evt;
      end
   end

   // Peripheral enable registers
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         pen_q <= {irq_entry_pkg::EN_RST, irq_entry_pkg::EN_RST};
      end else begin
         if (wr_en && PADDR_I == irq_entry_pkg::ENA_OFF)
            pen_q[7:0] <= PWDATA_I[7:0];
         if (wr_en && PADDR_I == irq_entry_pkg::ENB_OFF)
            pen_q[15:8] <= PWDATA_I[7:0];
      end
   end

   // Qualified request: any pending and enabled, gated by global
   // Core sources need no group enable, peripheral ones do
   assign core_en =
      ctrl_q[irq_entry_pkg::CEN_LSB +: irq_entry_pkg::CORE_SRC];
   assign core_flag =
      ctrl_q[irq_entry_pkg::CFL_LSB +: irq_entry_pkg::CORE_SRC];
   assign irq_any = |(core_en & core_flag)
                  | (ctrl_q[irq_entry_pkg::PGE_BIT]
                     & |(preq_q & pen_q));
   assign IRQ_REQ_O = irq_any & ctrl_q[irq_entry_pkg::GIE_BIT];
   // Accept only from run state, so a held flag during service waits
   assign take = IRQ_REQ_O && state_q == irq_entry_pkg::ST_RUN;
   assign gie_set = RETI_I && state_q == irq_entry_pkg::ST_SERVICE;

   // Entry sequence: flush now, then push/save/vector after the
   // fixed wait, giving the documented latency
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         state_q        <= irq_entry_pkg::ST_RUN;
         lat_q          <= 2'd0;
         CORE_CMD_O     <= '0;
         CORE_RESTORE_O <= 1'b0;
      end else begin
         CORE_CMD_O     <= '0;
         CORE_RESTORE_O <= 1'b0;
         case (state_q)
            irq_entry_pkg::ST_RUN: begin
               if (take) begin
                  CORE_CMD_O.flush <= 1'b1;
                  lat_q   <= 2'(irq_entry_pkg::ENTRY_CYCLES - 1);
                  state_q <= irq_entry_pkg::ST_ENTRY;
               end
            end
            irq_entry_pkg::ST_ENTRY: begin
               if (lat_q == 2'd1) begin
                  CORE_CMD_O.push     <= 1'b1;
                  CORE_CMD_O.save_ctx <= 1'b1;
                  CORE_CMD_O.load_pc  <= 1'b1;
                  CORE_CMD_O.pc       <= irq_entry_pkg::VECTOR_ADDR;
                  state_q <= irq_entry_pkg::ST_SERVICE;
               end
               lat_q <= lat_q - 2'd1;
            end
            irq_entry_pkg::ST_SERVICE: begin
               if (RETI_I) begin
                  CORE_RESTORE_O <= 1'b1;
                  state_q <= irq_entry_pkg::ST_RUN;
               end
            end
            default: state_q <= irq_entry_pkg::ST_RUN;
         endcase
      end
   end

   // Helper: cycles since acceptance; clears the cycle after the vector load so the
   // latency checks below see both ends of the entry window
   always_ff @(posedge CLK_SYS_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         wait_q <= 4'h0;
      end else if (take) begin
         wait_q <= 4'h1;
      end else if (wait_q != 4'h0 && !CORE_CMD_O.load_pc) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         wait_q <= 4'h0;
      end
   end

   // Entry sequence; the core relies on this exact order of pulses
   entry_clears_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      take |=> !ctrl_q[irq_entry_pkg::GIE_BIT])
      else $error("global enable not cleared on entry");

   flush_first_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      take |=> CORE_CMD_O.flush)
      else $error("prefetch not flushed");

   flush_single_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      CORE_CMD_O.flush |=> !CORE_CMD_O.flush)
      else $error("prefetch flushed twice for one entry");

   vector_load_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      take |-> ##3 (CORE_CMD_O.load_pc
                    && CORE_CMD_O.pc == irq_entry_pkg::VECTOR_ADDR))
      else $error("vector not loaded in time");

   ctx_save_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      CORE_CMD_O.load_pc |-> CORE_CMD_O.save_ctx && CORE_CMD_O.push)
      else $error("context not saved with vector load");

   // Latency window, counted from acceptance of the request
   latency_bound_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      wait_q <= 4'h3)
      else $error("entry latency too long");

   latency_floor_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      CORE_CMD_O.load_pc |-> wait_q == 4'h3)
      else $error("vector loaded too early");

   // Request gating by the enable hierarchy
   req_gated_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      !ctrl_q[irq_entry_pkg::GIE_BIT] |-> !IRQ_REQ_O)
      else $error("request while global enable clear");

   periph_group_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      (!ctrl_q[irq_entry_pkg::PGE_BIT] && !(|(core_en & core_flag)))
      |-> !IRQ_REQ_O)
      else $error("peripheral request without group enable");

   pending_served_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      (IRQ_REQ_O && state_q == irq_entry_pkg::ST_RUN)
      |=> (CORE_CMD_O.flush && state_q == irq_entry_pkg::ST_ENTRY))
      else $error("pending request not accepted");

   // Pending flags: every event lands, whatever the enables say
   for (genvar h = 0; h < 16; h++) begin : g_flag_chk
      flag_sets_a: assert property (
         @(posedge CLK_SYS_I) disable iff (!RSTN_I)
         per_evt[h] |=> preq_q[h])
         else $error("pending flag not set by event");
   end

   core_flag_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      CORE_EVT_I[0] |=> core_flag[0])
      else $error("core flag not set by event");

   // Service and return; a flush in service would corrupt the stack
   no_redirect_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      state_q == irq_entry_pkg::ST_SERVICE |=> !CORE_CMD_O.flush)
      else $error("redirect during service");

   return_sets_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      gie_set |=> ctrl_q[irq_entry_pkg::GIE_BIT] && CORE_RESTORE_O)
      else $error("return did not restore");

   restore_run_a: assert property (
      @(posedge CLK_SYS_I) disable iff (!RSTN_I)
      CORE_RESTORE_O |-> state_q == irq_entry_pkg::ST_RUN)
      else $error("restore without leaving service");
endmodule : irq_entry_return

/* File: dv/core_model.sv */
/*
 Core-side partner: counts entry commands and answers with return pulses.
 Assumes one-cycle command pulses on the system clock.
*/
`timescale 1ns/100ps
module core_model (
   input  wire logic                        clk_i,
   input  wire logic                        rstn_i,
   input  wire irq_entry_pkg::core_cmd_type cmd_i,
   input  wire logic                        restore_i,
   input  wire logic                        ret_req_i,
   output      logic                        reti_o,
   output      logic [14:0]                 pc_o,
   output      int                          entries_o,
   output      int                          flushes_o,
   output      int                          restores_o
);
   logic in_svc_q;
   // Return only while a routine runs, like a real decoder would
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         reti_o   <= 1'b0;
         in_svc_q <= 1'b0;
         pc_o     <= 15'h0100;
      end else begin
         pc_o   <= pc_o + 15'h0001; // Moving PC so pushes differ
         reti_o <= ret_req_i && in_svc_q;
         if (reti_o) in_svc_q <= 1'b0;
         if (cmd_i.flush) flushes_o <= flushes_o + 1;
         // Entry counts only when push, save, vector load and vector address come together
         if (cmd_i.push && cmd_i.save_ctx && cmd_i.load_pc &&
             cmd_i.pc === irq_entry_pkg::VECTOR_ADDR) begin
            entries_o <= entries_o + 1;
            in_svc_q  <= 1'b1;
         end
         if (restore_i) restores_o <= restores_o + 1;
      end
   end
endmodule : core_model

/* File: dv/irq_entry_return_tb.sv */
/*
 Self-checking bench for the interrupt entry block.
 Assumes zero-wait APB slave and the core model beside it.
*/
`timescale 1ns/100ps
module irq_entry_return_tb;
   logic clk = 1'b0, rstn, psel, penable, pwrite, ret_req, reti;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, r, seed = 32'hD3B5F607;
   logic [15:0] pevt;
   logic [2:0] cevt;
   logic [14:0] pc;
   logic req, pready, pslverr, restore, slverr;
   irq_entry_pkg::core_cmd_type cmd;
   int entries, flushes, restores, k, cyc, err_count, check_count;
   irq_entry_return #(.NUM_PERIPH(16)) u_dut (.CLK_SYS_I(clk),
      .RSTN_I(rstn), .CORE_EVT_I(cevt), .PERIPH_EVT_I(pevt),
      .RETI_I(reti), .CORE_PC_I(pc), .CORE_CMD_O(cmd),
      .CORE_RESTORE_O(restore), .IRQ_REQ_O(req), .PSEL_I(psel),
      .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
      .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr));
   core_model u_core (.clk_i(clk), .rstn_i(rstn), .cmd_i(cmd),
      .restore_i(restore), .ret_req_i(ret_req), .reti_o(reti),
      .pc_o(pc), .entries_o(entries), .flushes_o(flushes),
      .restores_o(restores));
   // Clock at 50 MHz
   initial begin
      forever #10 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   // Flag register that holds a given peripheral source
   function automatic logic [7:0] req_off(input int n);
      return n < 8 ? irq_entry_pkg::REQA_OFF : irq_entry_pkg::REQB_OFF;
   endfunction : req_off
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Waits on pready, never a fixed count
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge clk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      r = prdata;
      slverr = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk("read", e, r);
      chk("pslverr", 32'h0, slverr);
   endtask : rd
   task automatic settle(input int ne, input int nr);
      repeat (40) if (entries != ne || restores != nr) @(posedge clk);
      chk("entries", ne, entries);
      chk("flushes", ne, flushes);
      chk("restores", nr, restores);
   endtask : settle
   task automatic pulse(input int n, input logic core);
      @(posedge clk);
      if (core) cevt[n] <= 1'b1; else pevt[n] <= 1'b1;
      @(posedge clk);
      {cevt, pevt} <= 19'h0;
      repeat (4) @(posedge clk);
   endtask : pulse
   task automatic ret;
      @(posedge clk);
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
   endtask : ret
   task automatic close_out;
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : close_out
   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         close_out;
      end
   end
   initial begin
      {rstn, psel, penable, pwrite, paddr, pwdata} = 44'h0;
      {pevt, cevt, ret_req} = 20'h0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      rd(irq_entry_pkg::CTRL_OFF, 32'h0);
      // Edge sources first, then random ones
      for (int i = 0; i < 6; i++) begin
         seed = xs(seed);
         k = (i == 0) ? 0 : (i == 1) ? 15 : int'(seed[3:0]);
         pulse(k, 1'b0);
         rd(req_off(k), 32'h1 << (k % 8));
         chk("req", 32'h0, req);
         apb(1'b1, req_off(k), 32'h0);
      end
      apb(1'b1, irq_entry_pkg::ENA_OFF, 32'h1);
      apb(1'b1, irq_entry_pkg::CTRL_OFF, 32'h80);
      pulse(0, 1'b0);
      chk("req", 32'h0, req);
      apb(1'b1, irq_entry_pkg::CTRL_OFF, 32'hC0);
      // One cycle of request stands before the entry clears it
      @(negedge clk);
      chk("req", 32'h1, req);
      settle(1, 0);
      rd(irq_entry_pkg::STAT_OFF, 32'(irq_entry_pkg::ST_SERVICE));
      rd(irq_entry_pkg::CTRL_OFF, 32'h40);
      apb(1'b1, irq_entry_pkg::CTRL_OFF, 32'h48);
      pulse(0, 1'b1);
      chk("req", 32'h0, req);
      settle(1, 0);
      rd(irq_entry_pkg::CTRL_OFF, 32'h49);
      apb(1'b1, irq_entry_pkg::REQA_OFF, 32'h0);
      ret();
      settle(2, 1);
      rd(irq_entry_pkg::CTRL_OFF, 32'h49);
      apb(1'b1, irq_entry_pkg::CTRL_OFF, 32'h48);
      ret();
      settle(2, 2);
      rd(irq_entry_pkg::CTRL_OFF, 32'hC8);
      chk("req", 32'h0, req);
      apb(1'b1, 8'h3C, 32'hFFFFFFFF);
      rd(8'h3C, 32'h0);
      rd(irq_entry_pkg::ENA_OFF, 32'h1);
      apb(1'b1, irq_entry_pkg::ENB_OFF, 32'h80);
      rd(irq_entry_pkg::ENB_OFF, 32'h80);
      // Second reset in mid-run
      @(posedge clk);
      rstn <= 1'b0;
      @(posedge clk);
      rstn <= 1'b1;
      rd(irq_entry_pkg::CTRL_OFF, 32'h0);
      rd(irq_entry_pkg::ENA_OFF, 32'h0);
      rd(irq_entry_pkg::ENB_OFF, 32'h0);
      close_out;
   end
endmodule : irq_entry_return_tb
